// ---- cbag_core.v ----
// Bank address generator and special register datapath
`timescale 1ns/10ps
`include "cbag_defs.vh"
module cbag_core #(
	parameter AW = 24,
	parameter RBP_W = `CBAG_RBP_WIDTH
) (
	input wire clk_sys,
	input wire rst_b,
	input wire [7:0] reset_vec_bank,
	input wire [15:0] reset_vec_pc,
	// Instruction side
	input wire instr_start,
	input wire [3:0] addr_mode,
	input wire [2:0] rw_index,
	input wire [1:0] addr_src,
	input wire [23:0] lin_operand,
	input wire [31:0] long_reg_value,
	input wire [15:0] offset,
	input wire use_pc_base,
	input wire prefix_valid,
	input wire [2:0] prefix_space,
	input wire [1:0] acc_size,
	input wire acc_write,
	input wire [31:0] wr_data,
	input wire acc_start,
	// Program counter control
	input wire pc_load,
	input wire [15:0] pc_value,
	input wire pc_step,
	input wire [1:0] pc_step_len,
	input wire int_accept,
	input wire [15:0] int_vec_pc,
	input wire [7:0] int_vec_bank,
	// Special register writes
	input wire data_bank_we,
	input wire user_stack_bank_we,
	input wire system_stack_bank_we,
	input wire additional_bank_we,
	input wire direct_page_we,
	input wire user_stack_pointer_we,
	input wire system_stack_pointer_we,
	input wire status_word_we,
	input wire acc_we,
	input wire [31:0] sreg_wdata,
	input wire [2:0] reg_sel,
	// Outputs: memory bus, derived addresses and special registers
	output reg [23:0] mem_addr,
	output reg [7:0] mem_wdata,
	output reg mem_we,
	output reg mem_req,
	output reg acc_busy,
	output reg [23:0] fetch_addr,
	output reg [23:0] regfile_addr,
	output reg [7:0] program_bank_reg,
	output reg [7:0] data_bank_reg,
	output reg [7:0] user_stack_bank_reg,
	output reg [7:0] system_stack_bank_reg,
	output reg [7:0] additional_bank_reg,
	output reg [7:0] direct_page_reg,
	output reg [15:0] user_stack_pointer,
	output reg [15:0] system_stack_pointer,
	output reg [15:0] processor_status_word,
	output reg [15:0] accumulator_high_half,
	output reg [15:0] accumulator_low_half,
	output reg [15:0] program_counter,
	output reg [15:0] active_stack_pointer
);

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	reg rst_s1_r;
	reg rst_s2_r;
	wire rst_n;

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	assign rst_n = rst_s2_r;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Default space per addressing mode
	function [2:0] default_space;
		input [3:0] mode;
		input [2:0] rw;
		begin
			default_space = `CBAG_SP_PROG;
			if (mode == `CBAG_MODE_IND_RW) begin
				if (rw == 3'h3 || rw == 3'h7)
					default_space = `CBAG_SP_STACK;
				else if (rw == 3'h2 || rw == 3'h6)
					default_space = `CBAG_SP_ADD;
				else
					default_space = `CBAG_SP_DATA;
			end else if (mode == `CBAG_MODE_IND_ACC || mode == `CBAG_MODE_ABS16 ||
				mode == `CBAG_MODE_DIR) begin
				default_space = `CBAG_SP_DATA;
			end else if (mode == `CBAG_MODE_WORD_PUSH_INSTRUCTION || mode == `CBAG_MODE_WORD_POP_INSTRUCTION ||
				mode == `CBAG_MODE_INTSAVE) begin
				default_space = `CBAG_SP_STACK;
			end
		end
	endfunction

	wire stack_flag;
	assign stack_flag = processor_status_word[5];

	reg [7:0] stack_bank;
	always @* begin
		stack_bank = stack_flag ? system_stack_bank_reg : user_stack_bank_reg;
	end

	function [7:0] space_bank;
		input [2:0] sp;
		input [7:0] prog_bk;
		input [7:0] data_bk;
		input [7:0] stack_bk;
		input [7:0] add_bk;
		begin
			if (sp == `CBAG_SP_DATA)
				space_bank = data_bk;
			else if (sp == `CBAG_SP_STACK)
				space_bank = stack_bk;
			else if (sp == `CBAG_SP_ADD)
				space_bank = add_bk;
			else
				space_bank = prog_bk;
		end
	endfunction

	// ----------------------------------------
	// Prefix latch, one instruction only
	// ----------------------------------------
	reg pfx_pend_r;
	reg [2:0] pfx_space_r;
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pfx_pend_r <= 1'b0;
			pfx_space_r <= `CBAG_SP_NONE;
		end else if (prefix_valid) begin
			pfx_pend_r <= 1'b1;
			pfx_space_r <= prefix_space;
		end else if (instr_start) begin
			pfx_pend_r <= 1'b0;
		end
	end

	reg [2:0] eff_space;
	reg [7:0] eff_bank;
	reg [15:0] eff_off;
	reg [23:0] base_addr;
	always @* begin
		eff_space = pfx_pend_r ? pfx_space_r : default_space(addr_mode, rw_index);
		eff_bank = space_bank(eff_space, program_bank_reg, data_bank_reg, stack_bank,
			additional_bank_reg);
		eff_off = use_pc_base ? program_counter + offset : offset;
		if (addr_src == `CBAG_SRC_LIN_OPND)
			base_addr = lin_operand;
		else if (addr_src == `CBAG_SRC_LIN_LONG)
			base_addr = long_reg_value[23:0];
		else
			base_addr = {eff_bank, eff_off};
	end

	// ----------------------------------------
	// Multi-byte access sequencer
	// ----------------------------------------
	// Linear accesses carry across banks; bank accesses wrap in the offset
	reg st_r;
	reg [1:0] cnt_r;
	reg [1:0] last_r;
	reg [23:0] start_r;
	reg lin_r;
	reg [31:0] data_r;
	reg [15:0] off_nxt;
	always @* begin
		off_nxt = start_r[15:0] + {14'h0000, cnt_r} + 16'h0001;
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= `CBAG_ST_IDLE;
			cnt_r <= 2'h0;
			last_r <= 2'h0;
			start_r <= 24'h00_0000;
			lin_r <= 1'b0;
			data_r <= 32'h0000_0000;
			mem_addr <= 24'h00_0000;
			mem_wdata <= 8'h00;
			mem_we <= 1'b0;
			mem_req <= 1'b0;
			acc_busy <= 1'b0;
		end else begin
			case (st_r)
			`CBAG_ST_IDLE: begin
				mem_req <= 1'b0;
				mem_we <= 1'b0;
				if (acc_start) begin
					st_r <= (acc_size == `CBAG_SZ_BYTE) ? `CBAG_ST_IDLE : `CBAG_ST_BUSY;
					acc_busy <= (acc_size != `CBAG_SZ_BYTE);
					cnt_r <= 2'h0;
					last_r <= acc_size;
					start_r <= base_addr;
					lin_r <= (addr_src != `CBAG_SRC_BANK);
					data_r <= {8'h00, wr_data[31:8]};
					mem_addr <= base_addr;
					mem_wdata <= wr_data[7:0];
					mem_we <= acc_write;
					mem_req <= 1'b1;
				end
			end
			default: begin
				cnt_r <= cnt_r + 2'h1;
				mem_addr <= lin_r ? start_r + {22'h00_0000, cnt_r} + 24'h00_0001 :
					{start_r[23:16], off_nxt};
				mem_wdata <= data_r[7:0];
				data_r <= {8'h00, data_r[31:8]};
				if (cnt_r + 2'h1 == last_r) begin
					st_r <= `CBAG_ST_IDLE;
					acc_busy <= 1'b0;
				end
			end
			endcase
		end
	end

	// ----------------------------------------
	// Special registers
	// ----------------------------------------
	// Reset vector pins are sampled after release, not under reset
	reg boot_r;
	reg [15:0] status_nxt;
	always @* begin
		status_nxt = processor_status_word;
		if (status_word_we)
			status_nxt = sreg_wdata[15:0];
		if (int_accept)
			status_nxt[5] = 1'b1;
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			boot_r <= 1'b1;
			program_bank_reg <= `CBAG_BANK_RESET;
			data_bank_reg <= `CBAG_BANK_RESET;
			user_stack_bank_reg <= `CBAG_BANK_RESET;
			system_stack_bank_reg <= `CBAG_BANK_RESET;
			additional_bank_reg <= `CBAG_BANK_RESET;
			direct_page_reg <= 8'h00;
			user_stack_pointer <= 16'h0000;
			system_stack_pointer <= 16'h0000;
			processor_status_word <= 16'h0020;
			accumulator_high_half <= 16'h0000;
			accumulator_low_half <= 16'h0000;
			program_counter <= 16'h0000;
		end else begin
			boot_r <= 1'b0;
			if (data_bank_we)
				data_bank_reg <= sreg_wdata[7:0];
			if (user_stack_bank_we)
				user_stack_bank_reg <= sreg_wdata[7:0];
			if (system_stack_bank_we)
				system_stack_bank_reg <= sreg_wdata[7:0];
			if (additional_bank_we)
				additional_bank_reg <= sreg_wdata[7:0];
			if (direct_page_we)
				direct_page_reg <= sreg_wdata[7:0];
			if (user_stack_pointer_we)
				user_stack_pointer <= sreg_wdata[15:0];
			if (system_stack_pointer_we)
				system_stack_pointer <= sreg_wdata[15:0];
			if (acc_we) begin
				accumulator_high_half <= sreg_wdata[31:16];
				accumulator_low_half <= sreg_wdata[15:0];
			end
			processor_status_word <= status_nxt;
			if (boot_r) begin
				program_bank_reg <= reset_vec_bank;
				program_counter <= reset_vec_pc;
			end else if (int_accept) begin
				program_bank_reg <= int_vec_bank;
				program_counter <= int_vec_pc;
			end else if (pc_load) begin
				program_counter <= pc_value;
			end else if (pc_step) begin
				program_counter <= program_counter + {14'h0000, pc_step_len} + 16'h0001;
			end
		end
	end

	// ----------------------------------------
	// Derived address outputs
	// ----------------------------------------
	reg [23:0] rf_base;
	always @* begin
		rf_base = `CBAG_REGFILE_BASE +
			({19'h0_0000, processor_status_word[12:8]} << `CBAG_RBP_STRIDE_SHIFT);
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fetch_addr <= 24'h00_0000;
			regfile_addr <= `CBAG_REGFILE_BASE;
			active_stack_pointer <= 16'h0000;
		end else begin
			fetch_addr <= {program_bank_reg, program_counter};
			// Word i sits at base+2i; byte aliases follow from little-endian order
			regfile_addr <= rf_base + {20'h0_0000, reg_sel, 1'b0};
			active_stack_pointer <= stack_flag ? system_stack_pointer :
				user_stack_pointer;
		end
	end

endmodule

// ---- cbag_defs.vh ----
// Constants for the bank address generator
`ifndef CBAG_DEFS_VH
`define CBAG_DEFS_VH
`define CBAG_BANK_RESET 8'h00
`define CBAG_REGFILE_BASE 24'h00_0180
`define CBAG_REGFILE_LAST 24'h00_037F
`define CBAG_RBP_STRIDE_SHIFT 4
`define CBAG_RBP_WIDTH 5
// Address source select
`define CBAG_SRC_BANK 2'h0
`define CBAG_SRC_LIN_OPND 2'h1
`define CBAG_SRC_LIN_LONG 2'h2
// Addressing modes
`define CBAG_MODE_PROG 4'h0
`define CBAG_MODE_BRANCH 4'h1
`define CBAG_MODE_PCREL 4'h2
`define CBAG_MODE_IND_RW 4'h3
`define CBAG_MODE_IND_ACC 4'h4
`define CBAG_MODE_ABS16 4'h5
`define CBAG_MODE_DIR 4'h6
`define CBAG_MODE_WORD_PUSH_INSTRUCTION 4'h7
`define CBAG_MODE_WORD_POP_INSTRUCTION 4'h8
`define CBAG_MODE_INTSAVE 4'h9
// Spaces
`define CBAG_SP_PROG 3'h0
`define CBAG_SP_DATA 3'h1
`define CBAG_SP_STACK 3'h2
`define CBAG_SP_ADD 3'h3
`define CBAG_SP_NONE 3'h7
// Access sizes
`define CBAG_SZ_BYTE 2'h0
`define CBAG_SZ_WORD 2'h1
`define CBAG_SZ_LONG 2'h3
// Access sequencer states
`define CBAG_ST_IDLE 1'b0
`define CBAG_ST_BUSY 1'b1
`endif

// ---- cbag_bus_model.sv ----
// Memory bus partner model that records every byte cycle
`timescale 1ns/10ps
module cbag_bus_model (
	input wire clk_sys,
	input wire mem_req,
	input wire mem_we,
	input wire [23:0] mem_addr,
	input wire [7:0] mem_wdata
);
	// Log of {we, addr, data}; the bench drains it per access
	logic [32:0] log_q[$];
	always @(posedge clk_sys) begin
		if (mem_req === 1'b1) begin
			log_q.push_back({mem_we, mem_addr, mem_wdata});
		end
	end
endmodule

// ---- cbag_core_monitor.sv ----
// Port checker for the bank address generator
`timescale 1ns/10ps
module cbag_core_monitor (
	input wire clk_sys,
	input wire rst_b,
	input wire acc_start,
	input wire acc_busy,
	input wire [1:0] acc_size,
	input wire [1:0] addr_src,
	input wire mem_req,
	input wire [23:0] mem_addr,
	input wire [23:0] fetch_addr,
	input wire [7:0] program_bank_reg,
	input wire [15:0] program_counter,
	input wire [23:0] regfile_addr,
	input wire [15:0] processor_status_word,
	input wire [2:0] reg_sel,
	input wire int_accept,
	input wire [15:0] int_vec_pc,
	input wire [7:0] int_vec_bank
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	property p_fetch;
		fetch_addr == {$past(program_bank_reg), $past(program_counter)};
	endproperty
	a_fetch: assert property (p_fetch) else $error("bad fetch address");
	property p_rf;
		regfile_addr == 24'h00_0180 + {$past(processor_status_word[12:8]), 4'h0}
			+ {$past(reg_sel), 1'b0};
	endproperty
	a_rf: assert property (p_rf) else $error("bad register file address");
	property p_rf_range;
		regfile_addr >= 24'h00_0180 && regfile_addr <= 24'h00_037F;
	endproperty
	a_rf_range: assert property (p_rf_range) else $error("register file out of range");
	property p_int;
		int_accept |=> processor_status_word[5] && program_counter == $past(int_vec_pc)
			&& program_bank_reg == $past(int_vec_bank);
	endproperty
	a_int: assert property (p_int) else $error("bad interrupt entry");
	property p_word;
		acc_start && !acc_busy && acc_size == 2'h1 |=> mem_req ##1 mem_req ##1 !mem_req;
	endproperty
	a_word: assert property (p_word) else $error("word not two bytes");
	property p_long;
		acc_start && !acc_busy && acc_size == 2'h3 |=> mem_req [*4] ##1 !mem_req;
	endproperty
	a_long: assert property (p_long) else $error("long not four bytes");
	property p_byte;
		acc_start && !acc_busy && acc_size == 2'h0 |=> mem_req && !acc_busy ##1 !mem_req;
	endproperty
	a_byte: assert property (p_byte) else $error("byte not one cycle");
	// Only bank mode keeps the bank; linear mode carries upward
	property p_wrap;
		mem_req && acc_busy && addr_src == 2'h0 |=> mem_req
			&& mem_addr == {$past(mem_addr[23:16]), $past(mem_addr[15:0]) + 16'h0001};
	endproperty
	a_wrap: assert property (p_wrap) else $error("bad next byte address");
endmodule
bind cbag_core cbag_core_monitor u_cbag_core_monitor (.*);

// ---- test_cbag_core.sv ----
// Testbench for the bank address generator
`timescale 1ns/10ps
`include "cbag_defs.vh"
module test_cbag_core;
	logic clk_sys = 0;
	logic rst_b = 0;
	logic instr_start, use_pc_base, prefix_valid, acc_write, acc_start, pc_load, pc_step;
	logic int_accept, data_bank_we, user_stack_bank_we, system_stack_bank_we, additional_bank_we;
	logic direct_page_we, user_stack_pointer_we, system_stack_pointer_we, status_word_we, acc_we;
	logic [1:0] addr_src, acc_size, pc_step_len;
	logic [2:0] rw_index, prefix_space, reg_sel;
	logic [3:0] addr_mode;
	logic [7:0] reset_vec_bank, int_vec_bank, bk;
	logic [15:0] reset_vec_pc, offset, pc_value, int_vec_pc;
	logic [23:0] lin_operand;
	logic [31:0] long_reg_value, wr_data, sreg_wdata;
	wire [23:0] mem_addr, fetch_addr, regfile_addr;
	wire [7:0] mem_wdata, program_bank_reg, data_bank_reg, user_stack_bank_reg;
	wire [7:0] system_stack_bank_reg, additional_bank_reg, direct_page_reg;
	wire [15:0] user_stack_pointer, system_stack_pointer, processor_status_word;
	wire [15:0] accumulator_high_half, accumulator_low_half, program_counter;
	wire [15:0] active_stack_pointer;
	wire mem_we, mem_req, acc_busy;
	int num_errors = 0;
	int check_count = 0;
	cbag_core u_cbag_core (.*);
	cbag_bus_model u_cbag_bus_model (.*);
	always #5 clk_sys = ~clk_sys;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Bits from msb: 4 banks, page, 2 pointers, status, acc, prefix, instr, int, load, step
	task automatic strobe(logic [13:0] p, logic [31:0] v);
		@(negedge clk_sys);
		{data_bank_we, user_stack_bank_we, system_stack_bank_we, additional_bank_we,
			direct_page_we, user_stack_pointer_we, system_stack_pointer_we, status_word_we,
			acc_we, prefix_valid, instr_start, int_accept, pc_load, pc_step} = p;
		sreg_wdata = v;
		@(negedge clk_sys);
		{data_bank_we, user_stack_bank_we, system_stack_bank_we, additional_bank_we,
			direct_page_we, user_stack_pointer_we, system_stack_pointer_we, status_word_we,
			acc_we, prefix_valid, instr_start, int_accept, pc_load, pc_step} = 14'h0000;
		@(negedge clk_sys);
	endtask
	task automatic acc(logic [3:0] m, logic [2:0] rw, logic [1:0] src, logic [1:0] sz,
		logic [15:0] off, logic [23:0] a0);
		int n;
		logic [32:0] e;
		logic [23:0] ea;
		n = sz + 1;
		@(negedge clk_sys);
		{addr_mode, rw_index, addr_src, acc_size, offset, acc_start} = {m, rw, src, sz, off, 1'b1};
		@(negedge clk_sys);
		acc_start = 0;
		for (int i = 0; i < 12 && u_cbag_bus_model.log_q.size() < n; i++) @(negedge clk_sys);
		@(negedge clk_sys);
		chk("bytes", n, u_cbag_bus_model.log_q.size());
		for (int i = 0; i < n; i++) begin
			e = u_cbag_bus_model.log_q.pop_front();
			ea = src == 2'h0 ? {a0[23:16], a0[15:0] + 16'(i)} : a0 + 24'(i);
			chk("addr", ea, e[31:8]);
			chk("dir", acc_write, e[32]);
			if (acc_write) chk("data", wr_data[8*i+:8], e[7:0]);
		end
		chk("busy", 0, acc_busy);
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{instr_start, use_pc_base, prefix_valid, acc_write, acc_start, pc_load, pc_step,
			int_accept, data_bank_we, user_stack_bank_we, system_stack_bank_we,
			additional_bank_we, direct_page_we, user_stack_pointer_we, system_stack_pointer_we,
			status_word_we, acc_we,
			addr_src, acc_size, pc_step_len, rw_index, prefix_space, reg_sel, addr_mode,
			int_vec_bank, offset, pc_value, int_vec_pc, lin_operand, long_reg_value,
			wr_data, sreg_wdata} = '0;
		{reset_vec_bank, reset_vec_pc} = 24'hA5_1234;
		repeat (5) @(negedge clk_sys);
		rst_b = 1;
		repeat (6) @(negedge clk_sys);
		chk("banks", 0, {data_bank_reg, user_stack_bank_reg, system_stack_bank_reg,
			additional_bank_reg});
		chk("status", 16'h0020, processor_status_word);
		chk("fetch", 24'hA5_1234, fetch_addr);
		chk("rfile", 24'h00_0180, regfile_addr);
		$display("reset test done");
		strobe(14'h2000, 32'h0011);
		strobe(14'h1000, 32'h0022);
		strobe(14'h0800, 32'h0033);
		strobe(14'h0400, 32'h0044);
		chk("banks", 32'h1122_3344, {data_bank_reg, user_stack_bank_reg,
			system_stack_bank_reg, additional_bank_reg});
		for (int r = 0; r < 8; r++) begin
			bk = r[1:0] == 2'h2 ? 8'h44 : r[1:0] == 2'h3 ? 8'h33 : 8'h11;
			acc(`CBAG_MODE_IND_RW, 3'(r), 2'h0, 2'h0, 16'h0100, {bk, 16'h0100});
		end
		for (int m = 0; m < 10; m++) begin
			bk = m < 3 ? 8'hA5 : m < 7 ? 8'h11 : 8'h33;
			if (m != 3) acc(4'(m), 3'h0, 2'h0, 2'h0, 16'h0200, {bk, 16'h0200});
		end
		$display("space test done");
		strobe(14'h0100, 32'h5555);
		strobe(14'h0080, 32'hAAAA);
		strobe(14'h0040, 32'h0000);
		chk("user_sp", 16'h5555, active_stack_pointer);
		acc(`CBAG_MODE_WORD_PUSH_INSTRUCTION, 3'h0, 2'h0, 2'h0, 16'h0300, 24'h22_0300);
		{int_vec_pc, int_vec_bank} = 24'h08_007E;
		strobe(14'h0004, 32'h0000);
		chk("int", 32'h7E_0800, {program_bank_reg, program_counter});
		chk("system_sp", 16'hAAAA, active_stack_pointer);
		use_pc_base = 1;
		acc(`CBAG_MODE_PCREL, 3'h0, 2'h0, 2'h0, 16'h0010, 24'h7E_0810);
		use_pc_base = 0;
		$display("stack test done");
		prefix_space = `CBAG_SP_ADD;
		strobe(14'h0010, 32'h0000);
		acc(`CBAG_MODE_IND_RW, 3'h0, 2'h0, 2'h0, 16'h0400, 24'h44_0400);
		strobe(14'h0008, 32'h0000);
		acc(`CBAG_MODE_IND_RW, 3'h0, 2'h0, 2'h0, 16'h0400, 24'h11_0400);
		$display("prefix test done");
		acc_write = 1;
		wr_data = 32'hCAFE_BEEF;
		acc(`CBAG_MODE_ABS16, 3'h0, 2'h0, `CBAG_SZ_WORD, 16'hFFFF, 24'h11_FFFF);
		acc(`CBAG_MODE_ABS16, 3'h0, 2'h0, `CBAG_SZ_LONG, 16'hFFFE, 24'h11_FFFE);
		lin_operand = 24'h12_FFFF;
		acc(`CBAG_MODE_ABS16, 3'h0, 2'h1, `CBAG_SZ_WORD, 16'h0000, 24'h12_FFFF);
		long_reg_value = 32'hFF34_5678;
		acc(`CBAG_MODE_ABS16, 3'h0, 2'h2, 2'h0, 16'h0000, 24'h34_5678);
		acc_write = 0;
		$display("multibyte test done");
		reg_sel = 3'h7;
		strobe(14'h0040, 32'h1F00);
		chk("rfile", 24'h00_037E, regfile_addr);
		pc_value = 16'hFFFF;
		strobe(14'h0002, 32'h0000);
		pc_step_len = 2'h1;
		strobe(14'h0001, 32'h0000);
		chk("fetch", 24'h7E_0001, fetch_addr);
		strobe(14'h0200, 32'h0066);
		strobe(14'h0020, 32'h1357_9BDF);
		chk("direct_page", 8'h66, direct_page_reg);
		chk("acc", 32'h1357_9BDF, {accumulator_high_half, accumulator_low_half});
		$display("register test done");
		print_verdict;
	end
	// Run needs well under a thousand cycles
	initial begin
		#20000;
		num_errors++;
		print_verdict;
	end
endmodule
